// ### hdl/petu_pkg.sv
// shared types and constants of the program event trigger unit
package petu_pkg;
    localparam int NUM_AXES = 8;
    localparam int NUM_INPUTS = 24;
    localparam int POS_W = 32;
    localparam int CLK_HZ = 100_000_000;
    localparam int MS_PER_S = 1000;
    localparam int TICK_MS = 1;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S * TICK_MS;
    localparam logic [7:0] STOP_CODE_TIMEOUT = 8'h63;
    localparam logic [4:0] INPUTS_SMALL = 5'h08;
    localparam logic [4:0] INPUTS_LARGE = 5'h18;
    localparam logic [2:0] AXES_SMALL = 3'h4;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_WAIT_MOTION_COMPLETE,
        OP_WAIT_RELATIVE_DISTANCE,
        OP_WAIT_INCREMENTAL_DISTANCE,
        OP_WAIT_ABSOLUTE_POSITION,
        OP_WAIT_FORWARD_CROSSING,
        OP_WAIT_REVERSE_CROSSING,
        OP_WAIT_IN_POSITION,
        OP_WAIT_INPUT_LEVEL,
        OP_WAIT_SLEW_SPEED,
        OP_WAIT_REFERENCE_TIME,
        OP_WAIT_PATH_DISTANCE,
        OP_WAIT_DELAY
    } petu_op_type;

    // one decoded trigger instruction from the sequencer
    typedef struct packed {
        petu_op_type op;
        logic [NUM_AXES-1:0] axis_mask;
        logic seq_sel;
        logic signed [POS_W-1:0] operand;
    } petu_cmd_type;

    // per-axis status from the motion profilers and encoders
    typedef struct packed {
        logic [NUM_AXES-1:0] motion_done;
        logic [NUM_AXES-1:0] at_slew;
        logic [NUM_AXES-1:0] moving_fwd;
        logic [NUM_AXES-1:0] moving_rev;
        logic seq_done;
        logic seq_at_slew;
    } petu_axis_status_type;
endpackage : petu_pkg

// ### hdl/petu_trigger_unit.sv
// event trigger unit that stalls the program sequencer until a condition trips
// Overview of operation
// - with no trigger pending, sequencer advance is passed straight through
// - a decoded trigger stalls advance until its condition trips
// - motion-complete waits for all listed axes or sequence; empty means all
// - relative wait: commanded position moved distance from move start point
// - incremental wait counts from last distance wait and sets the new base
// - absolute wait holds until one axis reaches programmed position
// - forward crossing trips on reaching the point, or at once if past
// - reverse crossing trips on reaching the point, or at once if past
// - in-position waits for profile done and encoder reaching target
// - in-position timeout releases the wait and sets stop code 99
// - on timeout a running program is sent to the timeout handler
// - input wait: positive operand wants high level, negative wants low
// - input lines 1..8 on small models, 1..24 on large models
// - slew wait holds until each listed axis or sequence is at slew
// - negative reference wait trips after n ms and moves reference to then
// - path wait holds until programmed vector distance is travelled
// - delay wait holds n ms from decode
`timescale 1ns/1ps
`default_nettype none
module petu_trigger_unit (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic large_model,
    input wire logic cmd_valid,
    input wire petu_pkg::petu_cmd_type cmd,
    input wire logic seq_step_req,
    input wire logic servo_sample,
    input wire logic program_running,
    input wire petu_pkg::petu_axis_status_type axis_status,
    input wire logic [petu_pkg::NUM_AXES*petu_pkg::POS_W-1:0] cmd_pos,
    input wire logic [petu_pkg::NUM_AXES*petu_pkg::POS_W-1:0] enc_pos,
    input wire logic [petu_pkg::NUM_AXES*petu_pkg::POS_W-1:0] move_start_pos,
    input wire logic [petu_pkg::NUM_AXES*petu_pkg::POS_W-1:0] in_pos_timeout,
    input wire logic [petu_pkg::POS_W-1:0] path_dist,
    input wire logic [petu_pkg::NUM_INPUTS-1:0] input_pins,
    output logic seq_advance,
    output logic trigger_busy,
    output logic trip_pulse,
    output logic cmd_rejected,
    output logic jump_to_timeout_handler,
    output logic stop_code_wr,
    output logic [2:0] stop_code_axis,
    output logic [7:0] stop_code
);
    import petu_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic signed [POS_W-1:0] pick(
        input logic [NUM_AXES*POS_W-1:0] bus,
        input logic [2:0] idx
    );
        pick = bus[idx*POS_W +: POS_W];
    endfunction : pick

    // lowest set bit wins; masks with more bits are refused elsewhere
    function automatic logic [2:0] first_axis(
        input logic [NUM_AXES-1:0] m
    );
        first_axis = 3'h0;
        for (int i = NUM_AXES - 1; i >= 0; i--) begin
            if (m[i]) begin
                first_axis = 3'(i);
            end
        end
    endfunction : first_axis

    function automatic logic signed [POS_W-1:0] mag(
        input logic signed [POS_W-1:0] v
    );
        mag = (v < 0) ? -v : v;
    endfunction : mag

    // ************************************************************
    // input synchronisers
    // ************************************************************
    // only in_sync_q is read; in_meta_q may still be settling
    logic [NUM_INPUTS-1:0] in_meta_q;
    logic [NUM_INPUTS-1:0] in_sync_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            in_meta_q <= '0;
            in_sync_q <= '0;
        end else begin
            in_meta_q <= input_pins;
            in_sync_q <= in_meta_q;
        end
    end

    // ************************************************************
    // millisecond time base
    // ************************************************************
    // free-running so both time waits share one phase; resolution is 1 ms
    localparam int TICK_W = $clog2(CYC_PER_MS);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYC_PER_MS - 1);
    logic [TICK_W-1:0] div_q;
    logic [POS_W-1:0] ms_now_q;
    wire ms_tick = (div_q == TICK_LAST);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
            ms_now_q <= '0;
        end else begin
            div_q <= ms_tick ? '0 : div_q + 1'b1;
            ms_now_q <= ms_now_q + POS_W'(ms_tick);
        end
    end

    // ************************************************************
    // pending trigger
    // ************************************************************
    typedef enum logic [1:0] {S_IDLE, S_WAIT} petu_state_type;
    petu_state_type state_q;
    petu_cmd_type cur_q;
    logic [2:0] axis_q;
    logic signed [POS_W-1:0] base_q;
    logic signed [POS_W-1:0] incr_base_q;
    logic [POS_W-1:0] t_start_q;
    logic [POS_W-1:0] ref_time_q;
    logic [POS_W-1:0] to_cnt_q;
    logic [POS_W-1:0] path_base_q;

    // ************************************************************
    // command checks
    // ************************************************************
    wire [2:0] new_axis = first_axis(cmd.axis_mask);
    wire one_axis = $onehot(cmd.axis_mask);
    wire [4:0] max_in = large_model ? INPUTS_LARGE : INPUTS_SMALL;
    wire [POS_W-1:0] in_line = POS_W'(mag(cmd.operand));
    wire in_ok = (in_line >= 1) && (in_line <= POS_W'(max_in));
    wire axis_ok = large_model || (new_axis < AXES_SMALL);
    wire needs_one = cmd.op inside {OP_WAIT_RELATIVE_DISTANCE,
        OP_WAIT_INCREMENTAL_DISTANCE, OP_WAIT_ABSOLUTE_POSITION,
        OP_WAIT_FORWARD_CROSSING, OP_WAIT_REVERSE_CROSSING,
        OP_WAIT_IN_POSITION};
    wire bad_cmd = (cmd.op == OP_NONE)
        || (needs_one && !(one_axis && axis_ok))
        || (cmd.op == OP_WAIT_INPUT_LEVEL && !in_ok);
    wire accept = cmd_valid && (state_q == S_IDLE) && !bad_cmd;
    // reference-time zero only captures the reference, no wait
    wire ref_set = accept && cmd.op == OP_WAIT_REFERENCE_TIME
        && cmd.operand == 0;
    wire take_wait = accept && !ref_set;
    // a restarted sequence brings path_dist back below the base; measuring
    // from zero then avoids a huge wrapped distance
    wire path_restart = path_dist < path_base_q;
    wire [POS_W-1:0] path_from = path_restart ? '0 : path_base_q;

    // ************************************************************
    // trip conditions
    // ************************************************************
    wire signed [POS_W-1:0] c_pos = pick(cmd_pos, axis_q);
    wire signed [POS_W-1:0] e_pos = pick(enc_pos, axis_q);
    wire signed [POS_W-1:0] tgt = cur_q.operand;
    wire signed [POS_W-1:0] moved = c_pos - base_q;
    wire [NUM_AXES-1:0] done_mask = (cur_q.axis_mask == '0 && !cur_q.seq_sel)
        ? '1 : cur_q.axis_mask;
    wire done_all = &(axis_status.motion_done | ~done_mask)
        && (!cur_q.seq_sel || axis_status.seq_done);
    wire slew_all = &(axis_status.at_slew | ~cur_q.axis_mask)
        && (!cur_q.seq_sel || axis_status.seq_at_slew);
    wire dist_hit = (tgt >= 0) ? (moved >= tgt) : (moved <= tgt);
    // direction is fixed at accept, so a target behind the start waits for the axis to come back to it
    wire abs_hit = (base_q <= tgt) ? (c_pos >= tgt) : (c_pos <= tgt);
    wire fwd_hit = c_pos >= tgt;
    wire rev_hit = c_pos <= tgt;
    wire enc_hit = (base_q <= tgt) ? (e_pos >= tgt) : (e_pos <= tgt);
    wire inpos_hit = axis_status.motion_done[axis_q] && enc_hit;
    wire [POS_W-1:0] to_lim = POS_W'(pick(in_pos_timeout, axis_q));
    wire inpos_expired = axis_status.motion_done[axis_q] && to_lim != '0
        && to_cnt_q >= to_lim;
    // line n sits at bit n-1; the range was checked when it was taken
    wire [4:0] in_idx = 5'(POS_W'(mag(tgt)) - 1);
    wire in_hit = in_sync_q[in_idx] == (tgt > 0);
    wire [POS_W-1:0] ref_el = ms_now_q - ref_time_q;
    wire [POS_W-1:0] ref_lim = POS_W'(mag(tgt));
    wire at_hit = ref_el >= ref_lim;
    wire path_hit = (path_dist - path_from) >= POS_W'(tgt);
    wire delay_hit = (ms_now_q - t_start_q) >= POS_W'(tgt);

    logic cond;
    always_comb begin
        case (cur_q.op)
            OP_WAIT_MOTION_COMPLETE: cond = done_all;
            OP_WAIT_RELATIVE_DISTANCE: cond = dist_hit;
            OP_WAIT_INCREMENTAL_DISTANCE: cond = dist_hit;
            OP_WAIT_ABSOLUTE_POSITION: cond = abs_hit;
            OP_WAIT_FORWARD_CROSSING: cond = fwd_hit;
            OP_WAIT_REVERSE_CROSSING: cond = rev_hit;
            OP_WAIT_IN_POSITION: cond = inpos_hit || inpos_expired;
            OP_WAIT_INPUT_LEVEL: cond = in_hit;
            OP_WAIT_SLEW_SPEED: cond = slew_all;
            OP_WAIT_REFERENCE_TIME: cond = at_hit;
            OP_WAIT_PATH_DISTANCE: cond = path_hit;
            OP_WAIT_DELAY: cond = delay_hit;
            default: cond = 1'b1;
        endcase
    end

    // conditions are sampled only on servo samples, as the profilers update
    wire trip = (state_q == S_WAIT) && servo_sample && cond;
    // a trip with the target still unreached can only be the timeout
    wire timed_out = trip && cur_q.op == OP_WAIT_IN_POSITION && !inpos_hit;
    wire path_trip = trip && cur_q.op == OP_WAIT_PATH_DISTANCE;

    // base for a new command: start of move, incremental base or position
    logic signed [POS_W-1:0] base_d;
    always_comb begin
        case (cmd.op)
            OP_WAIT_RELATIVE_DISTANCE:
                base_d = pick(move_start_pos, new_axis);
            OP_WAIT_INCREMENTAL_DISTANCE: base_d = incr_base_q;
            OP_WAIT_IN_POSITION: base_d = pick(enc_pos, new_axis);
            default: base_d = pick(cmd_pos, new_axis);
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
        end else if (take_wait) begin
            state_q <= S_WAIT;
        end else if (trip) begin
            state_q <= S_IDLE;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_q <= '0;
            axis_q <= '0;
            base_q <= '0;
            t_start_q <= '0;
        end else if (take_wait) begin
            cur_q <= cmd;
            axis_q <= new_axis;
            base_q <= base_d;
            t_start_q <= ms_now_q;
        end
    end

    // ************************************************************
    // bases kept between triggers
    // ************************************************************
    wire dist_trip = trip && (cur_q.op == OP_WAIT_RELATIVE_DISTANCE
        || cur_q.op == OP_WAIT_INCREMENTAL_DISTANCE);
    wire period_trip = trip && cur_q.op == OP_WAIT_REFERENCE_TIME && tgt < 0;
    // the timeout only runs once the profile is done, so a long move
    // cannot expire before it has had a chance to settle
    wire to_run = state_q == S_WAIT && ms_tick
        && axis_status.motion_done[axis_q];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            incr_base_q <= '0;
        end else if (dist_trip) begin
            incr_base_q <= c_pos;
        end
    end

    // stepping by the period, not to now, keeps the cadence free of drift
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ref_time_q <= '0;
        end else if (ref_set) begin
            ref_time_q <= ms_now_q;
        end else if (period_trip) begin
            ref_time_q <= ref_time_q + ref_lim;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            to_cnt_q <= '0;
        end else if (accept) begin
            to_cnt_q <= '0;
        end else if (to_run) begin
            to_cnt_q <= to_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            path_base_q <= '0;
        end else if (path_trip) begin
            path_base_q <= path_dist;
        end else if (path_restart) begin
            path_base_q <= '0;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    wire busy_d = (state_q == S_WAIT) ? !trip : take_wait;
    wire adv_d = (state_q == S_IDLE) ? (seq_step_req && !accept)
        || ref_set : trip;
    wire rej_d = cmd_valid && (state_q == S_IDLE) && bad_cmd;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seq_advance <= 1'b0;
            trigger_busy <= 1'b0;
            trip_pulse <= 1'b0;
            cmd_rejected <= 1'b0;
        end else begin
            seq_advance <= adv_d;
            trigger_busy <= busy_d;
            trip_pulse <= trip;
            cmd_rejected <= rej_d;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            jump_to_timeout_handler <= 1'b0;
            stop_code_wr <= 1'b0;
        end else begin
            jump_to_timeout_handler <= timed_out && program_running;
            stop_code_wr <= timed_out;
        end
    end

    // axis and code hold together until the next timeout replaces both
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stop_code_axis <= '0;
            stop_code <= '0;
        end else begin
            stop_code_axis <= timed_out ? axis_q : stop_code_axis;
            stop_code <= timed_out ? STOP_CODE_TIMEOUT : stop_code;
        end
    end
endmodule : petu_trigger_unit
`default_nettype wire

// ### dv/petu_far_side.sv
// far-side model: servo strobe and a ramping commanded position
`timescale 1ns/1ps
`default_nettype none
module petu_far_side
    import petu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic run,
    output logic servo_sample,
    output logic [NUM_AXES*POS_W-1:0] cmd_pos
);
    logic [1:0] div_q;
    initial begin
        div_q = 2'h0;
        servo_sample = 1'b0;
        cmd_pos = '0;
    end
    // one sample in four keeps trip latencies short but not trivial
    always @(negedge ref_clk) begin
        div_q <= div_q + 2'h1;
        servo_sample <= (div_q == 2'h3);
        if (run && div_q == 2'h3) begin
            cmd_pos[POS_W-1:0] <= cmd_pos[POS_W-1:0] + 32'h10;
        end
    end
endmodule : petu_far_side
`default_nettype wire

// ### dv/petu_trigger_unit_assertions.sv
// port-level assertion checker for the event trigger unit
`timescale 1ns/1ps
`default_nettype none
module petu_trigger_unit_assertions (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic large_model,
    input wire logic cmd_valid,
    input wire petu_pkg::petu_cmd_type cmd,
    input wire logic seq_step_req,
    input wire logic servo_sample,
    input wire logic seq_advance,
    input wire logic trigger_busy,
    input wire logic trip_pulse,
    input wire logic cmd_rejected
);
    import petu_pkg::*;
    wire logic take = cmd_valid && !trigger_busy && !seq_advance;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_release;
        trip_pulse && seq_advance && !trigger_busy;
    endsequence
    a_step_advance: assert property (
        seq_step_req && !trigger_busy && !cmd_valid |=> seq_advance)
        else $error("step request not answered");
    a_busy_release: assert property (
        $fell(trigger_busy) |-> s_release)
        else $error("busy dropped without a trip");
    a_busy_stall: assert property (
        trigger_busy |-> !seq_advance)
        else $error("advance while a trigger is pending");
    a_trip_sample: assert property (
        trip_pulse |-> $past(servo_sample))
        else $error("trip outside a servo sample");
    a_accept_busy: assert property (
        take && cmd.op == OP_WAIT_MOTION_COMPLETE |=> trigger_busy)
        else $error("motion wait not pending");
    a_none_refused: assert property (
        take && cmd.op == OP_NONE |=> cmd_rejected && !trigger_busy)
        else $error("empty command not refused");
    a_ref_zero: assert property (
        take && cmd.op == OP_WAIT_REFERENCE_TIME && cmd.operand == 0
        |=> seq_advance && !trigger_busy)
        else $error("reference capture stalled");
    a_line_range: assert property (
        take && cmd.op == OP_WAIT_INPUT_LEVEL && !large_model
        && cmd.operand == 9 |=> cmd_rejected)
        else $error("line 9 taken on small model");
endmodule : petu_trigger_unit_assertions
bind petu_trigger_unit petu_trigger_unit_assertions
    petu_trigger_unit_assertions_i (.ref_clk, .rst, .large_model,
    .cmd_valid, .cmd, .seq_step_req, .servo_sample, .seq_advance,
    .trigger_busy, .trip_pulse, .cmd_rejected);
`default_nettype wire

// ### dv/petu_trigger_unit_tb_top.sv
// self-checking bench for the program event trigger unit
`timescale 1ns/1ps
`default_nettype none
module petu_trigger_unit_tb_top;
    import petu_pkg::*;
    logic ref_clk, rst, large_model, cmd_valid, seq_step_req, hi;
    logic program_running, servo_sample, run;
    logic seq_advance, trigger_busy, trip_pulse, cmd_rejected;
    logic jump, sc_wr;
    logic [2:0] sc_axis;
    logic [7:0] sc;
    petu_cmd_type cmd;
    petu_axis_status_type axis_status;
    logic [NUM_AXES*POS_W-1:0] cmd_pos;
    logic [NUM_INPUTS-1:0] input_pins;
    logic [7:0] mask, need;
    logic signed [POS_W-1:0] tgt;
    int fails, n_tests, seed, ln;
    petu_trigger_unit petu_trigger_unit_i (.ref_clk, .rst, .large_model,
        .cmd_valid, .cmd, .seq_step_req, .servo_sample, .program_running,
        .axis_status, .cmd_pos, .enc_pos(cmd_pos), .move_start_pos('0),
        .in_pos_timeout('0), .path_dist('0), .input_pins, .seq_advance,
        .trigger_busy, .trip_pulse, .cmd_rejected,
        .jump_to_timeout_handler(jump), .stop_code_wr(sc_wr),
        .stop_code_axis(sc_axis), .stop_code(sc));
    petu_far_side petu_far_side_i (.ref_clk, .run, .servo_sample,
        .cmd_pos);
    // ***************************************************************
    // helpers
    // ***************************************************************
    function automatic logic signed [31:0] in_op(int n, logic h);
        return h ? n : -n;
    endfunction : in_op
    task automatic check(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (e !== g) begin
            fails++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask : check
    task automatic issue(input petu_op_type op, input logic [7:0] m,
                         input logic signed [31:0] v);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd = '{op, m, 1'b0, v};
        @(negedge ref_clk);
        cmd_valid = 1'b0;
    endtask : issue
    // bounded so a missing trip shows as a mismatch, not a hang
    task automatic wait_trip(input string nm);
        for (int k = 0; k < 64 && seq_advance !== 1'b1; k++) begin
            @(negedge ref_clk);
        end
        check(nm, 1, trip_pulse);
    endtask : wait_trip
    task automatic give_verdict;
        if (fails == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        give_verdict();
    end
    initial begin
        seed = 14193;
        {rst, program_running, large_model} = 3'h7;
        {cmd_valid, seq_step_req, run} = 3'h0;
        cmd = '0;
        axis_status = '0;
        input_pins = '0;
        fails = 0;
        n_tests = 0;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) begin
            @(negedge ref_clk);
            seq_step_req = 1'b1;
            @(negedge ref_clk);
            seq_step_req = 1'b0;
            check("advance", 1, seq_advance);
            @(negedge ref_clk);
            check("advance end", 0, seq_advance);
        end
        for (int i = 0; i < 2; i++) begin
            mask = i ? 8'h00 : 8'($random(seed)) | 8'h01;
            need = (mask == 8'h00) ? 8'hFF : mask;
            axis_status.motion_done = ~need | (need & (need - 8'h01));
            issue(OP_WAIT_MOTION_COMPLETE, mask, 0);
            repeat (12) @(negedge ref_clk);
            check("done stall", 1, trigger_busy);
            axis_status.motion_done = need;
            wait_trip("done trip");
        end
        repeat (3) begin
            ln = 1 + ($unsigned($random(seed)) % 24);
            hi = 1'($random(seed));
            input_pins = {24{~hi}};
            issue(OP_WAIT_INPUT_LEVEL, 8'h00, in_op(ln, hi));
            repeat (12) @(negedge ref_clk);
            check("in stall", 1, trigger_busy);
            input_pins[ln-1] = hi;
            wait_trip("in trip");
        end
        large_model = 1'b0;
        issue(OP_WAIT_INPUT_LEVEL, 8'h00, 9);
        check("line 9 refused", 1, cmd_rejected);
        large_model = 1'b1;
        run = 1'b1;
        tgt = cmd_pos[31:0] + 32'h40;
        issue(OP_WAIT_ABSOLUTE_POSITION, 8'h01, tgt);
        check("abs stall", 1, trigger_busy);
        wait_trip("abs trip");
        check("abs reached", 1, cmd_pos[31:0] >= tgt);
        issue(OP_WAIT_FORWARD_CROSSING, 8'h01, cmd_pos[31:0] - 32'h20);
        wait_trip("fwd past");
        issue(OP_WAIT_REVERSE_CROSSING, 8'h01, cmd_pos[31:0] + 32'h100);
        wait_trip("rev past");
        issue(OP_WAIT_ABSOLUTE_POSITION, 8'h03, 0);
        check("two axes refused", 1, cmd_rejected);
        issue(OP_WAIT_RELATIVE_DISTANCE, 8'h01, cmd_pos[31:0] + 32'h40);
        check("rel stall", 1, trigger_busy);
        wait_trip("rel trip");
        issue(OP_WAIT_INCREMENTAL_DISTANCE, 8'h01, 32'h40);
        check("incr stall", 1, trigger_busy);
        wait_trip("incr trip");
        mask = 8'($random(seed)) | 8'h02;
        axis_status.at_slew = mask & ~8'h02;
        issue(OP_WAIT_SLEW_SPEED, mask, 0);
        repeat (12) @(negedge ref_clk);
        check("slew stall", 1, trigger_busy);
        axis_status.at_slew = mask;
        wait_trip("slew trip");
        axis_status.motion_done = 8'h00;
        issue(OP_WAIT_IN_POSITION, 8'h01, cmd_pos[31:0] + 32'h40);
        repeat (30) @(negedge ref_clk);
        check("inpos stall", 1, trigger_busy);
        axis_status.motion_done = 8'hFF;
        wait_trip("inpos trip");
        check("no timeout jump", 0, jump);
        check("no stop code", 0, {sc_wr, sc_axis, sc});
        issue(OP_WAIT_REFERENCE_TIME, 8'h00, 0);
        check("ref zero", 1, seq_advance);
        check("ref no busy", 0, trigger_busy);
        issue(OP_NONE, 8'h00, 0);
        check("none refused", 1, cmd_rejected);
        give_verdict();
    end
endmodule : petu_trigger_unit_tb_top
`default_nettype wire
